// ---- core/crs_pkg.sv ----
// package of constants and types for the core register set
package crs_pkg;

    // register bus map (byte offsets)
    localparam logic [11:0] CRS_OFF_GPR_BASE = 12'h000;
    localparam logic [11:0] CRS_OFF_SP       = 12'h034;
    localparam logic [11:0] CRS_OFF_LR       = 12'h038;
    localparam logic [11:0] CRS_OFF_PC       = 12'h03C;
    localparam logic [11:0] CRS_OFF_PSR      = 12'h040;
    localparam logic [11:0] CRS_OFF_APPLICATION_STATUS_PART     = 12'h044;
    localparam logic [11:0] CRS_OFF_INTERRUPT_STATUS_PART     = 12'h048;
    localparam logic [11:0] CRS_OFF_EXECUTION_STATUS_PART     = 12'h04C;
    localparam logic [11:0] CRS_OFF_PMASK    = 12'h050;
    localparam logic [11:0] CRS_OFF_FMASK    = 12'h054;
    localparam logic [11:0] CRS_OFF_BPRI     = 12'h058;
    localparam logic [11:0] CRS_OFF_CTRL     = 12'h05C;
    localparam logic [11:0] CRS_OFF_MSP      = 12'h060;
    localparam logic [11:0] CRS_OFF_PSP      = 12'h064;
    localparam logic [11:0] CRS_OFF_STAT     = 12'h068;
    localparam logic [11:0] CRS_OFF_EXC      = 12'h06C;

    localparam int CRS_NUM_GPR   = 13;
    localparam int CRS_NUM_LOW   = 8;

    // status word field masks, stack pointer and program counter alignment masks
    localparam logic [31:0] CRS_APPLICATION_STATUS_PART_MASK = 32'hF8000000;
    localparam logic [31:0] CRS_INTERRUPT_STATUS_PART_MASK = 32'h000001FF;
    localparam logic [31:0] CRS_EXECUTION_STATUS_PART_MASK = 32'h0700FC00;
    localparam logic [31:0] CRS_EXECUTION_STATUS_PART_T    = 32'h01000000;
    localparam int          CRS_T_BIT     = 24;
    localparam logic [31:0] CRS_SP_MASK   = 32'hFFFFFFFC;
    localparam logic [31:0] CRS_PC_MASK   = 32'hFFFFFFFE;

    localparam int CRS_CTRL_NPRIV = 0;
    localparam int CRS_CTRL_SPSEL = 1;
    localparam int CRS_PRIO_W     = 9;
    localparam logic [8:0] CRS_EXC_NMI  = 9'h002;
    localparam logic [8:0] CRS_EXC_HARD = 9'h003;

    localparam logic [1:0] CRS_RESP_OKAY   = 2'h0;
    localparam logic [1:0] CRS_RESP_SLVERR = 2'h2;

    // core-side register port write request
    typedef struct packed {
        logic        en;
        logic [3:0]  idx;
        logic        wide;
        logic [31:0] data;
    } crs_gpr_wr_t;

    // exception signalling
    typedef struct packed {
        logic       enter;
        logic       ret;
        logic [8:0] num;
    } crs_exc_t;

    typedef enum logic [1:0] {
        CRS_RD_IDLE = 2'b01,
        CRS_RD_RESP = 2'b10
    } crs_rd_state_t;

endpackage : crs_pkg

// ---- core/crs_core_regs.sv ----
// architectural register set of the processor core
`timescale 1ns/10ps
module crs_core_regs
    import crs_pkg::*;
(
    // clock and reset
    input  wire logic                 clk,
    input  wire logic                 arst_n,
    // axi4-lite write channels
    input  wire logic [11:0]          s_axi_awaddr,
    input  wire logic                 s_axi_awvalid,
    output logic                      s_axi_awready,
    input  wire logic [31:0]          s_axi_wdata,
    input  wire logic [3:0]           s_axi_wstrb,
    input  wire logic                 s_axi_wvalid,
    output logic                      s_axi_wready,
    output logic [1:0]                s_axi_bresp,
    output logic                      s_axi_bvalid,
    input  wire logic                 s_axi_bready,
    // axi4-lite read channels
    input  wire logic [11:0]          s_axi_araddr,
    input  wire logic                 s_axi_arvalid,
    output logic                      s_axi_arready,
    output logic [31:0]               s_axi_rdata,
    output logic [1:0]                s_axi_rresp,
    output logic                      s_axi_rvalid,
    input  wire logic                 s_axi_rready,
    // core execution write port
    input  wire crs_gpr_wr_t          core_wr,
    input  wire logic                 call_en,
    input  wire logic [31:0]          call_ret_addr,
    input  wire logic                 pc_wr_en,
    input  wire logic [31:0]          pc_wr_data,
    input  wire logic                 flags_wr_en,
    input  wire logic [4:0]           flags_wr_data,
    // exception interface
    input  wire crs_exc_t             exc,
    input  wire logic [CRS_PRIO_W-1:0] irq_prio,
    // read-back and status
    output logic [31:0]               stack_pointer,
    output logic [31:0]               program_counter_value,
    output logic                      handler_mode,
    output logic                      user_level,
    output logic                      irq_admit,
    output logic                      fault_pulse
);

    logic [1:0] rst_sync_q;
    logic       rst_n;
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rst_sync_q <= 2'b00;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_q[1];

    // architectural state
    logic [31:0]           gpr_q [CRS_NUM_GPR];
    logic [31:0]           main_stack_copy_q;
    logic [31:0]           process_stack_copy_q;
    logic [31:0]           return_address_register_q;
    logic [31:0]           pc_q;
    logic [31:0]           psr_q;
    logic                  priority_mask_all_q;
    logic                  fault_mask_all_q;
    logic [CRS_PRIO_W-1:0] base_priority_threshold_q;
    logic [1:0]            operating_mode_control_q;
    logic                  handler_q;
    logic                  fault_q;
    logic [31:0]           rdata_q;
    logic                  psp_sel;

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [31:0] msk);
        merge = (old & ~msk) | (nw & msk);
    endfunction : merge

    function automatic logic [31:0] strb_mask(input logic [3:0] s);
        strb_mask = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
    endfunction : strb_mask

    // privilege and stack selection
    assign psp_sel = !handler_q && operating_mode_control_q[CRS_CTRL_SPSEL];

    // axi write acceptance
    logic aw_have_q;
    logic w_have_q;
    logic [11:0] aw_addr_q;
    logic [31:0] w_data_q;
    logic [3:0]  w_strb_q;
    logic        wr_fire;
    logic        wr_hit;
    logic        wr_ok;
    logic [31:0] wm;
    assign wr_fire = aw_have_q && w_have_q && !s_axi_bvalid;
    assign wm      = strb_mask(w_strb_q);
    // user-level software may not write special registers
    assign wr_ok   = wr_hit && !(user_level && aw_addr_q >= CRS_OFF_PSR);

    always_comb begin
        wr_hit = 1'b0;
        if (aw_addr_q[1:0] == 2'b00 && aw_addr_q <= CRS_OFF_PSP) begin
            wr_hit = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            aw_have_q     <= 1'b0;
            w_have_q      <= 1'b0;
            aw_addr_q     <= 12'h000;
            w_data_q      <= 32'h00000000;
            w_strb_q      <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= CRS_RESP_OKAY;
        end else begin
            s_axi_awready <= !aw_have_q && !(s_axi_awvalid && s_axi_awready);
            s_axi_wready  <= !w_have_q && !(s_axi_wvalid && s_axi_wready);
            if (s_axi_awvalid && s_axi_awready) begin
                aw_have_q <= 1'b1;
                aw_addr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_have_q <= 1'b1;
                w_data_q <= s_axi_wdata;
                w_strb_q <= s_axi_wstrb;
            end
            if (wr_fire) begin
                aw_have_q    <= 1'b0;
                w_have_q     <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_ok ? CRS_RESP_OKAY : CRS_RESP_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    logic       bus_wr;
    logic [3:0] gidx;
    assign bus_wr = wr_fire && wr_ok;
    assign gidx   = aw_addr_q[5:2];

    // general purpose bank
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < CRS_NUM_GPR; i++) begin
                gpr_q[i] <= 32'h00000000;
            end
        end else begin
            if (bus_wr && aw_addr_q < CRS_OFF_SP) begin
                gpr_q[gidx] <= merge(gpr_q[gidx], w_data_q, wm);
            end
            if (core_wr.en && core_wr.idx < 4'(CRS_NUM_LOW)) begin
                gpr_q[core_wr.idx[2:0]] <= core_wr.data;
            end else if (core_wr.en && core_wr.wide && core_wr.idx < 4'(CRS_NUM_GPR)) begin
                gpr_q[core_wr.idx] <= core_wr.data;
            end
        end
    end

    // banked stack pointer
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            main_stack_copy_q    <= 32'h00000000;
            process_stack_copy_q <= 32'h00000000;
        end else begin
            if (bus_wr && aw_addr_q == CRS_OFF_SP) begin
                if (psp_sel) begin
                    process_stack_copy_q <= merge(process_stack_copy_q, w_data_q, wm) & CRS_SP_MASK;
                end else begin
                    main_stack_copy_q <= merge(main_stack_copy_q, w_data_q, wm) & CRS_SP_MASK;
                end
            end
            if (bus_wr && aw_addr_q == CRS_OFF_MSP) begin
                main_stack_copy_q <= merge(main_stack_copy_q, w_data_q, wm) & CRS_SP_MASK;
            end
            if (bus_wr && aw_addr_q == CRS_OFF_PSP) begin
                process_stack_copy_q <= merge(process_stack_copy_q, w_data_q, wm) & CRS_SP_MASK;
            end
        end
    end

    // return address and program counter
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            return_address_register_q <= 32'h00000000;
            pc_q                      <= 32'h00000000;
        end else begin
            if (bus_wr && aw_addr_q == CRS_OFF_LR) begin
                return_address_register_q <= merge(return_address_register_q, w_data_q, wm);
            end
            if (call_en) begin
                return_address_register_q <= call_ret_addr;
            end
            if (bus_wr && aw_addr_q == CRS_OFF_PC) begin
                pc_q <= merge(pc_q, w_data_q, wm) & CRS_PC_MASK;
            end
            if (pc_wr_en) begin
                pc_q <= pc_wr_data & CRS_PC_MASK;
            end
        end
    end

    // program status word, three parts
    logic [31:0] psr_wmask;
    logic        t_clear_try;
    always_comb begin
        psr_wmask = 32'h00000000;
        case (aw_addr_q)
            CRS_OFF_PSR:  psr_wmask = CRS_APPLICATION_STATUS_PART_MASK | CRS_EXECUTION_STATUS_PART_MASK;
            CRS_OFF_APPLICATION_STATUS_PART: psr_wmask = CRS_APPLICATION_STATUS_PART_MASK;
            CRS_OFF_EXECUTION_STATUS_PART: psr_wmask = CRS_EXECUTION_STATUS_PART_MASK;
            default:      psr_wmask = 32'h00000000;
        endcase
    end
    assign t_clear_try = bus_wr && (aw_addr_q == CRS_OFF_PSR || aw_addr_q == CRS_OFF_EXECUTION_STATUS_PART)
                         && w_strb_q[3] && !w_data_q[CRS_T_BIT];

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            psr_q <= CRS_EXECUTION_STATUS_PART_T;
        end else begin
            psr_q <= merge(psr_q, w_data_q, psr_wmask & wm & {32{bus_wr}}) | CRS_EXECUTION_STATUS_PART_T;
            if (flags_wr_en) begin
                psr_q[31:27] <= flags_wr_data;
            end
            if (exc.enter) begin
                psr_q[8:0] <= exc.num;
            end else if (exc.ret) begin
                psr_q[8:0] <= 9'h000;
            end
        end
    end

    // masks and control
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            priority_mask_all_q       <= 1'b0;
            fault_mask_all_q          <= 1'b0;
            base_priority_threshold_q <= '0;
            operating_mode_control_q  <= 2'b00;
            handler_q                 <= 1'b0;
        end else begin
            if (bus_wr && aw_addr_q == CRS_OFF_PMASK && w_strb_q[0]) begin
                priority_mask_all_q <= w_data_q[0];
            end
            if (bus_wr && aw_addr_q == CRS_OFF_FMASK && w_strb_q[0]) begin
                fault_mask_all_q <= w_data_q[0];
            end
            if (bus_wr && aw_addr_q == CRS_OFF_BPRI) begin
                base_priority_threshold_q <= CRS_PRIO_W'(merge({23'h0, base_priority_threshold_q},
                                                               w_data_q, wm));
            end
            if (bus_wr && aw_addr_q == CRS_OFF_CTRL && w_strb_q[0]) begin
                operating_mode_control_q[CRS_CTRL_NPRIV] <= w_data_q[CRS_CTRL_NPRIV];
                operating_mode_control_q[CRS_CTRL_SPSEL] <= w_data_q[CRS_CTRL_SPSEL]
                                                            && !handler_q;
            end
            if (exc.enter) begin
                handler_q <= 1'b1;
                operating_mode_control_q[CRS_CTRL_SPSEL] <= 1'b0;
            end else if (exc.ret) begin
                handler_q <= 1'b0;
            end
        end
    end

    // interrupt admission
    logic admit_d;
    always_comb begin
        admit_d = 1'b1;
        if (fault_mask_all_q) begin
            admit_d = (exc.num == CRS_EXC_NMI);
        end else if (priority_mask_all_q) begin
            admit_d = (exc.num == CRS_EXC_NMI) || (exc.num == CRS_EXC_HARD);
        end else if (base_priority_threshold_q != '0 && irq_prio >= base_priority_threshold_q
                     && exc.num != CRS_EXC_NMI && exc.num != CRS_EXC_HARD) begin
            admit_d = 1'b0;
        end
    end

    // outputs from flops
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            stack_pointer         <= 32'h00000000;
            program_counter_value <= 32'h00000000;
            handler_mode          <= 1'b0;
            user_level            <= 1'b0;
            irq_admit             <= 1'b0;
            fault_pulse           <= 1'b0;
            fault_q               <= 1'b0;
        end else begin
            stack_pointer         <= psp_sel ? process_stack_copy_q : main_stack_copy_q;
            program_counter_value <= pc_q;
            handler_mode          <= handler_q;
            user_level            <= !handler_q && operating_mode_control_q[CRS_CTRL_NPRIV];
            irq_admit             <= admit_d;
            fault_pulse           <= t_clear_try || (wr_fire && !wr_ok && wr_hit);
            fault_q               <= fault_q | t_clear_try;
        end
    end

    // axi read channel
    crs_rd_state_t rd_q;
    logic [31:0]   rd_val;
    logic          rd_hit;
    always_comb begin
        rd_val = 32'h00000000;
        rd_hit = 1'b1;
        if (s_axi_araddr < CRS_OFF_SP) begin
            rd_val = gpr_q[s_axi_araddr[5:2]];
        end else begin
            case (s_axi_araddr)
                CRS_OFF_SP:    rd_val = psp_sel ? process_stack_copy_q : main_stack_copy_q;
                CRS_OFF_LR:    rd_val = return_address_register_q;
                CRS_OFF_PC:    rd_val = pc_q;
                CRS_OFF_PSR:   rd_val = psr_q;
                CRS_OFF_APPLICATION_STATUS_PART:  rd_val = psr_q & CRS_APPLICATION_STATUS_PART_MASK;
                CRS_OFF_INTERRUPT_STATUS_PART:  rd_val = psr_q & CRS_INTERRUPT_STATUS_PART_MASK;
                CRS_OFF_EXECUTION_STATUS_PART:  rd_val = psr_q & (CRS_EXECUTION_STATUS_PART_MASK | CRS_EXECUTION_STATUS_PART_T);
                CRS_OFF_PMASK: rd_val = {31'h0, priority_mask_all_q};
                CRS_OFF_FMASK: rd_val = {31'h0, fault_mask_all_q};
                CRS_OFF_BPRI:  rd_val = {23'h0, base_priority_threshold_q};
                CRS_OFF_CTRL:  rd_val = {30'h0, operating_mode_control_q};
                CRS_OFF_MSP:   rd_val = main_stack_copy_q;
                CRS_OFF_PSP:   rd_val = process_stack_copy_q;
                CRS_OFF_STAT:  rd_val = {28'h0, fault_q, irq_admit, user_level, handler_q};
                default:       rd_hit = 1'b0;
            endcase
        end
        if (s_axi_araddr[1:0] != 2'b00) begin
            rd_hit = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_q          <= CRS_RD_IDLE;
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rresp   <= CRS_RESP_OKAY;
            rdata_q       <= 32'h00000000;
        end else begin
            case (rd_q)
                CRS_RD_IDLE: begin
                    s_axi_arready <= 1'b1;
                    if (s_axi_arvalid && s_axi_arready) begin
                        s_axi_arready <= 1'b0;
                        s_axi_rvalid  <= 1'b1;
                        rdata_q       <= rd_val;
                        s_axi_rresp   <= rd_hit ? CRS_RESP_OKAY : CRS_RESP_SLVERR;
                        rd_q          <= CRS_RD_RESP;
                    end
                end
                CRS_RD_RESP: begin
                    if (s_axi_rready) begin
                        s_axi_rvalid <= 1'b0;
                        rd_q         <= CRS_RD_IDLE;
                    end
                end
                default: rd_q <= CRS_RD_IDLE;
            endcase
        end
    end
    assign s_axi_rdata = rdata_q;

endmodule : crs_core_regs

// ---- verif/crs_core_regs_asserts.sv ----
// concurrent checks on the ports of the core register set
`timescale 1ns/10ps
module crs_core_regs_asserts
    import crs_pkg::*;
(
    // clock and reset
    input wire logic        clk,
    input wire logic        arst_n,
    // register bus
    input wire logic [11:0] s_axi_awaddr,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    // core side
    input wire logic        pc_wr_en,
    input wire logic [31:0] pc_wr_data,
    input wire crs_exc_t    exc,
    input wire logic [31:0] stack_pointer,
    input wire logic [31:0] program_counter_value,
    input wire logic        handler_mode,
    input wire logic        user_level,
    input wire logic        irq_admit,
    input wire logic        fault_pulse
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    logic [31:0] pc_exp_q;

    // expected program counter after a load
    always_ff @(posedge clk) begin
        if (pc_wr_en) pc_exp_q <= pc_wr_data & CRS_PC_MASK;
    end

    sequence user_wr_s;
        s_axi_awvalid && s_axi_awready && user_level && (s_axi_awaddr >= CRS_OFF_PSR);
    endsequence
    sequence nmi_held_s;
        (exc.num == CRS_EXC_NMI) [*2];
    endsequence

    sp_align_a: assert property (stack_pointer[1:0] == 2'h0)
        else $error("stack pointer not word aligned");
    pc_align_a: assert property (program_counter_value[0] == 1'b0)
        else $error("program counter bit zero set");
    pc_load_a: assert property (pc_wr_en |=> ##[0:1] program_counter_value == pc_exp_q)
        else $error("program counter load wrong");
    handler_priv_a: assert property (handler_mode |-> !user_level)
        else $error("user level in handler mode");
    exc_enter_a: assert property (exc.enter |-> ##[1:2] handler_mode && !user_level)
        else $error("no handler mode after entry");
    exc_ret_a: assert property (exc.ret |-> ##[1:2] !handler_mode)
        else $error("handler mode kept after return");
    nmi_admit_a: assert property (nmi_held_s |-> irq_admit)
        else $error("nonmaskable candidate refused");
    user_fault_a: assert property (user_wr_s |-> ##[1:3] fault_pulse)
        else $error("no fault on user special write");
    one_bresp_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write response repeated");
    one_rresp_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
        else $error("read response repeated");
endmodule : crs_core_regs_asserts

bind crs_core_regs crs_core_regs_asserts i_asserts (.*);

// ---- verif/crs_exec_model.sv ----
// model of the execution and exception logic that drives the register set
`timescale 1ns/10ps
module crs_exec_model
    import crs_pkg::*;
(
    // clock
    input wire logic                  clk,
    // towards the register set
    output crs_gpr_wr_t               core_wr,
    output logic                      call_en,
    output logic [31:0]               call_ret_addr,
    output logic                      pc_wr_en,
    output logic [31:0]               pc_wr_data,
    output logic                      flags_wr_en,
    output logic [4:0]                flags_wr_data,
    output crs_exc_t                  exc,
    output logic [CRS_PRIO_W-1:0]     irq_prio
);
    initial begin
        core_wr = '0;
        call_en = 1'b0;
        call_ret_addr = '0;
        pc_wr_en = 1'b0;
        pc_wr_data = '0;
        flags_wr_en = 1'b0;
        flags_wr_data = '0;
        exc = '0;
        irq_prio = '0;
    end

    // each request is one cycle wide, then one quiet cycle
    task automatic gpr(input logic [3:0] i, input logic w, input logic [31:0] d);
        core_wr <= '{1'b1, i, w, d};
        @(posedge clk);
        core_wr.en <= 1'b0;
        @(posedge clk);
    endtask : gpr

    task automatic call(input logic [31:0] a);
        call_en <= 1'b1;
        call_ret_addr <= a;
        @(posedge clk);
        call_en <= 1'b0;
        @(posedge clk);
    endtask : call

    task automatic pc(input logic [31:0] a);
        pc_wr_en <= 1'b1;
        pc_wr_data <= a;
        @(posedge clk);
        pc_wr_en <= 1'b0;
        @(posedge clk);
    endtask : pc

    task automatic flags(input logic [4:0] f);
        flags_wr_en <= 1'b1;
        flags_wr_data <= f;
        @(posedge clk);
        flags_wr_en <= 1'b0;
        @(posedge clk);
    endtask : flags

    task automatic enter(input logic [8:0] n);
        exc <= '{1'b1, 1'b0, n};
        @(posedge clk);
        exc.enter <= 1'b0;
        @(posedge clk);
    endtask : enter

    task automatic leave();
        exc.ret <= 1'b1;
        @(posedge clk);
        exc <= '0;
        @(posedge clk);
    endtask : leave

    // candidate held for three cycles
    task automatic cand(input logic [8:0] n, input logic [8:0] p);
        exc.num <= n;
        irq_prio <= p;
        repeat (3) @(posedge clk);
    endtask : cand
endmodule : crs_exec_model

// ---- verif/crs_core_regs_test.sv ----
// self-checking bench for the core register set
`timescale 1ns/10ps
module crs_core_regs_test
    import crs_pkg::*;
;
    logic clk = 1'b0, arst_n = 1'b0;
    logic [11:0] s_axi_awaddr = '0, s_axi_araddr = '0;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic [31:0] s_axi_wdata = '0, s_axi_rdata, rd_d, stack_pointer, program_counter_value;
    logic [3:0] s_axi_wstrb = '0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
    crs_gpr_wr_t core_wr;
    crs_exc_t exc;
    logic call_en, pc_wr_en, flags_wr_en, handler_mode, user_level, irq_admit, fault_pulse;
    logic [31:0] call_ret_addr, pc_wr_data;
    logic [4:0] flags_wr_data;
    logic [8:0] irq_prio;
    int failures = 0, num_checks = 0, cyc = 0, n_fault = 0, f0 = 0;

    crs_core_regs i_dut (.*);
    crs_exec_model i_model (.*);

    always #4 clk = ~clk;

    // fault pulse count, cycle ceiling
    always @(posedge clk) begin
        if (fault_pulse === 1'b1) n_fault <= n_fault + 1;
        cyc <= cyc + 1;
        if (cyc == 6000) begin
            failures++;
            wrap_up();
        end
    end

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        num_checks++;
        if (g !== e) begin
            failures++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk

    task automatic chk_b(input logic g, input logic e);
        chk({31'h0, g}, {31'h0, e});
    endtask : chk_b

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= 4'hF;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        forever begin
            @(posedge clk);
            if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
            if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid === 1'b1) break;
        end
        s_axi_bready <= 1'b0;
        rsp = s_axi_bresp;
    endtask : wr

    task automatic rd(input logic [11:0] a);
        @(posedge clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        forever begin
            @(posedge clk);
            if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid === 1'b1) break;
        end
        s_axi_rready <= 1'b0;
        rd_d = s_axi_rdata;
        rsp = s_axi_rresp;
    endtask : rd

    task automatic rchk(input logic [11:0] a, input logic [31:0] e);
        rd(a);
        chk(rd_d, e);
        chk({30'h0, rsp}, {30'h0, CRS_RESP_OKAY});
    endtask : rchk

    // set a mask, offer a candidate, look at admission
    task automatic mchk(input logic [11:0] a, input logic [31:0] v, input logic [8:0] n,
                        input logic [8:0] p, input logic e);
        wr(a, v);
        i_model.cand(n, p);
        chk_b(irq_admit, e);
        wr(a, 32'h0);
    endtask : mchk

    task automatic wrap_up();
        $display("checks=%0d failures=%0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : wrap_up

    initial begin
        repeat (2) @(posedge clk);
        arst_n <= 1'b1;
        repeat (4) @(posedge clk);
        rchk(CRS_OFF_PSR, CRS_EXECUTION_STATUS_PART_T);
        rchk(CRS_OFF_CTRL, 32'h0);
        for (int i = 0; i < CRS_NUM_GPR; i++) wr(12'(4 * i), 32'hA5000000 | 32'(i));
        for (int i = 0; i < CRS_NUM_GPR; i++) rchk(12'(4 * i), 32'hA5000000 | 32'(i));
        i_model.gpr(4'h3, 1'b0, 32'h00001111);
        rchk(12'h00C, 32'h00001111);
        i_model.gpr(4'h9, 1'b0, 32'h00002222);
        rchk(12'h024, 32'hA5000009);
        i_model.gpr(4'h9, 1'b1, 32'h00003333);
        rchk(12'h024, 32'h00003333);
        $display("test registers done");
        wr(CRS_OFF_SP, 32'h12345677);
        rchk(CRS_OFF_MSP, 32'h12345674);
        wr(CRS_OFF_PSP, 32'h00000203);
        rchk(CRS_OFF_PSP, 32'h00000200);
        chk(stack_pointer, 32'h12345674);
        i_model.call(32'h00008001);
        rchk(CRS_OFF_LR, 32'h00008001);
        i_model.pc(32'h00001003);
        rchk(CRS_OFF_PC, 32'h00001002);
        chk(program_counter_value, 32'h00001002);
        i_model.flags(5'h15);
        rchk(CRS_OFF_APPLICATION_STATUS_PART, 32'hA8000000);
        wr(CRS_OFF_EXECUTION_STATUS_PART, 32'hFFFFFFFF);
        rchk(CRS_OFF_EXECUTION_STATUS_PART, 32'h0700FC00);
        rchk(CRS_OFF_PSR, 32'hAF00FC00);
        wr(CRS_OFF_EXECUTION_STATUS_PART, 32'h0);
        rd(CRS_OFF_EXECUTION_STATUS_PART);
        chk(rd_d & CRS_EXECUTION_STATUS_PART_T, CRS_EXECUTION_STATUS_PART_T);
        chk_b(n_fault != 0, 1'b1);
        i_model.enter(9'h00B);
        rchk(CRS_OFF_INTERRUPT_STATUS_PART, 32'h0000000B);
        chk_b(handler_mode, 1'b1);
        i_model.leave();
        rchk(CRS_OFF_INTERRUPT_STATUS_PART, 32'h0);
        $display("test status done");
        mchk(CRS_OFF_PMASK, 32'h1, CRS_EXC_HARD, 9'h000, 1'b1);
        mchk(CRS_OFF_PMASK, 32'h1, 9'h010, 9'h000, 1'b0);
        mchk(CRS_OFF_FMASK, 32'h1, CRS_EXC_HARD, 9'h000, 1'b0);
        mchk(CRS_OFF_FMASK, 32'h1, CRS_EXC_NMI, 9'h000, 1'b1);
        mchk(CRS_OFF_BPRI, 32'h4, 9'h014, 9'h004, 1'b0);
        mchk(CRS_OFF_BPRI, 32'h4, 9'h014, 9'h003, 1'b1);
        mchk(CRS_OFF_BPRI, 32'h0, 9'h014, 9'h008, 1'b1);
        i_model.cand(9'h000, 9'h000);
        $display("test masks done");
        wr(CRS_OFF_CTRL, 32'h3);
        rchk(CRS_OFF_SP, 32'h00000200);
        chk_b(user_level, 1'b1);
        f0 = n_fault;
        wr(CRS_OFF_PMASK, 32'h1);
        chk({30'h0, rsp}, {30'h0, CRS_RESP_SLVERR});
        rchk(CRS_OFF_PMASK, 32'h0);
        chk_b(n_fault != f0, 1'b1);
        i_model.enter(9'h00F);
        rchk(CRS_OFF_CTRL, 32'h1);
        chk_b(user_level, 1'b0);
        chk(stack_pointer, 32'h12345674);
        wr(CRS_OFF_CTRL, 32'h0);
        i_model.leave();
        rd(12'h0FC);
        chk(rd_d, 32'h0);
        chk({30'h0, rsp}, {30'h0, CRS_RESP_SLVERR});
        $display("test modes done");
        wrap_up();
    end
endmodule : crs_core_regs_test
